// >>> eips_pkg.sv
package eips_pkg;

	localparam logic [7:0] EIPS_SFR_ADDR   = 8'hf6;
	localparam logic [7:0] EIPS_PAGE_LOW   = 8'h00;
	localparam logic [7:0] EIPS_PAGE_HIGH  = 8'h0f;
	localparam logic [7:0] EIPS_PRIO_RESET = 8'h00;

	localparam int EIPS_BIT_LIN    = 7;
	localparam int EIPS_BIT_TIMER3 = 6;
	localparam int EIPS_BIT_CMP_B  = 5;
	localparam int EIPS_BIT_CMP_A  = 4;
	localparam int EIPS_BIT_CNTARR = 3;
	localparam int EIPS_BIT_CONV   = 2;
	localparam int EIPS_BIT_WINDOW = 1;
	localparam int EIPS_BIT_SMBUS  = 0;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] page;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} eips_sfr_req_s;

	typedef struct packed {
		logic       lin_irq_prio;
		logic       timer3_irq_prio;
		logic       cmp_b_irq_prio;
		logic       cmp_a_irq_prio;
		logic       counter_array_irq_prio;
		logic       conv_done_irq_prio;
		logic       window_cmp_irq_prio;
		logic       smbus_irq_prio;
	} eips_prio_s;

endpackage

// >>> eips_prio_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: bit 7 sets lin interrupt priority, 0 low, 1 high.
// R2: bit 6 sets timer 3 interrupt priority, 0 low, 1 high.
// R3: bit 5 sets comparator b interrupt priority, 0 low, 1 high.
// R4: bit 4 sets comparator a interrupt priority, 0 low, 1 high.
// R5: bit 3 sets counter array interrupt priority, 0 low, 1 high.
// R6: bit 2 sets conversion-complete interrupt priority, 0 low, 1 high.
// R7: bit 1 sets window-compare interrupt priority, 0 low, 1 high.
// R8: bit 0 sets smbus interrupt priority, 0 low, 1 high.
// R9: register sits at 0xf6 on pages 0x00 and 0x0f, all bits rw.
// R10: high pending wins over low and may preempt a low service.
module eips_prio_select
	import eips_pkg::*;
(
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst_b,
	// special-function register access
	input  wire eips_sfr_req_s sfr_req,
	output logic [7:0]         sfr_rdata,
	// interrupt sources and core handshake
	input  wire logic [7:0]    irq_pend,
	input  wire logic          irq_ack,
	input  wire logic          irq_ret,
	output logic               irq_req,
	output logic [2:0]         irq_id,
	output logic               irq_high,
	// priority levels seen by the core
	output eips_prio_s         prio
);

	logic [7:0] prio_reg;
	logic [7:0] rdata_reg;
	logic       req_reg;
	logic [2:0] id_reg;
	logic       high_reg;
	logic       high_act_reg;
	logic       low_act_reg;

	wire logic       page_ok;
	wire logic       hit;
	wire logic [7:0] hi_cand;
	wire logic [7:0] lo_cand;
	wire logic [7:0] hi_one;
	wire logic [7:0] lo_one;
	wire logic       hi_ok;
	wire logic       lo_ok;
	wire logic [7:0] sel_one;
	wire logic [2:0] sel_id;

	// both pages decode the same location
	assign page_ok = (sfr_req.page == EIPS_PAGE_LOW) ||
		(sfr_req.page == EIPS_PAGE_HIGH); // see R9
	assign hit = page_ok && (sfr_req.addr == EIPS_SFR_ADDR); // see R9

	// a set bit puts that source in the high class
	assign hi_cand = irq_pend & prio_reg; // see R1 to R8
	assign lo_cand = irq_pend & ~prio_reg; // see R1 to R8
	// lowest source index wins inside a class
	assign hi_one = hi_cand & (~hi_cand + 8'h01);
	assign lo_one = lo_cand & (~lo_cand + 8'h01);

	// high may interrupt a low service, never another high one
	assign hi_ok = (|hi_cand) && !high_act_reg; // see R10
	// low waits until nothing at all is in service
	assign lo_ok = (|lo_cand) && !high_act_reg && !low_act_reg; // see R10
	assign sel_one = hi_ok ? hi_one : lo_one; // see R10

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_enc
			wire logic [7:0] m;
			for (genvar k = 0; k < 8; k++) begin : g_m
				assign m[k] = sel_one[k] & ((k >> g) & 1) != 0;
			end
			assign sel_id[g] = |m;
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prio_reg <= EIPS_PRIO_RESET;
		end else if (sfr_req.wr && hit) begin
			prio_reg <= sfr_req.wdata; // see R9
		end
	end

	// unmapped reads return zero
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
		end else if (sfr_req.rd) begin
			rdata_reg <= hit ? prio_reg : 8'h00; // see R9
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			req_reg  <= 1'b0;
			id_reg   <= 3'h0;
			high_reg <= 1'b0;
		end else begin
			req_reg  <= hi_ok || lo_ok; // see R10
			id_reg   <= sel_id;
			high_reg <= hi_ok;
		end
	end

	// one nesting level each; return unwinds the innermost first
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			high_act_reg <= 1'b0;
			low_act_reg  <= 1'b0;
		end else if (irq_ack && req_reg) begin
			if (high_reg) begin
				high_act_reg <= 1'b1; // see R10
			end else begin
				low_act_reg <= 1'b1;
			end
		end else if (irq_ret) begin
			if (high_act_reg) begin
				high_act_reg <= 1'b0;
			end else begin
				low_act_reg <= 1'b0;
			end
		end
	end

	assign sfr_rdata = rdata_reg;
	assign irq_req   = req_reg;
	assign irq_id    = id_reg;
	assign irq_high  = high_reg;
	assign prio      = prio_reg;

endmodule

// >>> eips_prio_select_sva.sv
`timescale 1ns/1ps
module eips_prio_select_sva
	import eips_pkg::*;
(
	input logic          clock,
	input logic          rst_b,
	input eips_sfr_req_s sfr_req,
	input logic [7:0]    sfr_rdata,
	input logic [7:0]    irq_pend,
	input logic          irq_req,
	input logic [2:0]    irq_id,
	input logic          irq_high,
	input eips_prio_s    prio
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [7:0] pv, pp;
	wire hit = sfr_req.addr == 8'hf6 && sfr_req.page inside {8'h00, 8'h0f};
	wire wr = hit && sfr_req.wr;
	// irq outputs lag one edge, so judge them on last edge's inputs
	always_ff @(posedge clock) begin
		pv <= prio;
		pp <= irq_pend;
	end
	property p_w; wr |=> prio == $past(sfr_req.wdata); endproperty
	a_w: assert property (p_w) else $error("write");
	property p_k; !wr |=> $stable(prio); endproperty
	a_k: assert property (p_k) else $error("hold");
	property p_r; hit && sfr_req.rd |=> sfr_rdata == $past(prio); endproperty
	a_r: assert property (p_r) else $error("read");
	property p_m; !hit && sfr_req.rd |=> sfr_rdata == 8'h00; endproperty
	a_m: assert property (p_m) else $error("miss");
	property p_c; irq_req |-> irq_high == pv[irq_id]; endproperty
	a_c: assert property (p_c) else $error("class");
	property p_i; irq_req |-> pp[irq_id]; endproperty
	a_i: assert property (p_i) else $error("id");
	property p_l; irq_req && !irq_high |-> (pp & pv) == 8'h00; endproperty
	a_l: assert property (p_l) else $error("low");
	property p_n; pp == 8'h00 |-> !irq_req; endproperty
	a_n: assert property (p_n) else $error("idle");
endmodule

// >>> extended_irq_priority_select_test.sv
`timescale 1ns/1ps
module extended_irq_priority_select_test;
	import eips_pkg::*;
	logic          clock = 0, rst_b = 0, irq_ack = 0, irq_ret = 0;
	logic [7:0]    irq_pend = 0, sfr_rdata;
	eips_sfr_req_s sfr_req = '0;
	logic          irq_req, irq_high;
	logic [2:0]    irq_id;
	eips_prio_s    prio;
	int            bad_count = 0, n_tests = 0;
	// page, data, read back, high and id
	logic [31:0]   tab [9] = '{32'h00808087, 32'h0f404086, 32'h00202085,
		32'h0f101084, 32'h00080883, 32'h0f040482, 32'h00020281,
		32'h0f010180, 32'h01020001};
	always #5 clock = ~clock;
	eips_prio_select i_eips_prio_select (.*);
	task chk(string n, logic [7:0] e, logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task acc(logic [7:0] p, logic [7:0] d, logic w);
		@(posedge clock);
		sfr_req <= {8'hf6, p, w, !w, d};
		@(posedge clock);
		sfr_req <= '0;
		@(posedge clock);
	endtask
	task close_out;
		$display("%0d checks %0d bad", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#3000;
		bad_count++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1;
		acc(8'h00, 8'h00, 0);
		chk("reset", 8'h00, sfr_rdata);
		foreach (tab[i]) begin
			acc(tab[i][31:24], tab[i][23:16], 1);
			acc(tab[i][31:24], 8'h00, 0);
			chk("read", tab[i][15:8], sfr_rdata);
			irq_pend <= tab[i][23:16];
			repeat (2) @(posedge clock);
			chk("irq", tab[i][7:0], {irq_high, 4'h0, irq_id});
			irq_pend <= 0;
		end
		// low service, then a high one preempting it
		acc(8'h00, 8'h80, 1);
		irq_pend <= 8'h01;
		repeat (2) @(posedge clock);
		chk("low", 8'h80, {irq_req, irq_high, 3'h0, irq_id});
		irq_ack <= 1;
		@(posedge clock);
		irq_ack  <= 0;
		irq_pend <= 8'h81;
		repeat (2) @(posedge clock);
		chk("preempt", 8'hc7, {irq_req, irq_high, 3'h0, irq_id});
		irq_ack <= 1;
		@(posedge clock);
		irq_ack <= 0;
		repeat (2) @(posedge clock);
		chk("masked", 8'h00, {irq_req, irq_high, 3'h0, irq_id});
		irq_ret <= 1;
		@(posedge clock);
		irq_ret <= 0;
		repeat (2) @(posedge clock);
		chk("unwind", 8'hc7, {irq_req, irq_high, 3'h0, irq_id});
		chk("prio", 8'h80, prio);
		irq_pend <= 0;
		// reset in mid-run clears the register
		rst_b <= 0;
		@(posedge clock);
		rst_b <= 1;
		acc(8'h0f, 8'h00, 0);
		chk("reset2", 8'h00, sfr_rdata);
		chk("prio2", 8'h00, prio);
		close_out;
	end
endmodule
bind eips_prio_select eips_prio_select_sva i_eips_prio_select_sva (.*);
